// ### verilog/pfs_pkg.sv
// Behaviour
// - Code 22 loads the program counter from the value field.
// - Code 23 pushes the program counter, then loads it from value.
// - The return stack holds at most eight entries.
// - A call with a full stack only advances the program counter.
// - Code 24 pops the newest entry; execution resumes after that call.
// - A return with an empty stack only advances the program counter.
// - Code 27 waits; type 0 to 4 selects the condition.
// - Type 0 stalls for the given number of ticks.
// - Type 1 stalls until the target position is reached.
// - Type 2 stalls until the home switch has triggered.
// - Type 3 stalls until either end switch has triggered.
// - Type 4 stalls until homing reports completion.
// - Types 1 to 4 take value as timeout; zero means none.
// - Value minus one takes the count from the accumulator.
// - An expired timeout sets a sticky timeout error flag.
// - The program counter holds at the wait address while waiting.
// - One tick lasts exactly ten milliseconds.
// - Conditional jump with condition 8 tests the timeout flag.
package pfs_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ      = 10_000_000;
   localparam int unsigned TICK_MS     = 10;
   localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

   // ------------------------------------------------------------
   // Instruction codes and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  OP_JUMP_CONDITIONAL = 8'h15;
   localparam logic [7:0]  OP_JUMP_ALWAYS      = 8'h16;
   localparam logic [7:0]  OP_CALL_SUBROUTINE  = 8'h17;
   localparam logic [7:0]  OP_RETURN_SUBROUTINE = 8'h18;
   localparam logic [7:0]  OP_WAIT             = 8'h1b;
   localparam logic [7:0]  JC_COND_TIMEOUT     = 8'h08;
   localparam logic [7:0]  WT_TICKS            = 8'h00;
   localparam logic [7:0]  WT_POSITION         = 8'h01;
   localparam logic [7:0]  WT_HOME_SWITCH      = 8'h02;
   localparam logic [7:0]  WT_END_SWITCH       = 8'h03;
   localparam logic [7:0]  WT_HOMING_DONE      = 8'h04;
   localparam logic [7:0]  MOTOR_ONLY          = 8'h00;
   localparam logic [31:0] VALUE_FROM_ACC      = 32'hffffffff;
   localparam int unsigned INSTR_OP_LSB        = 0;
   localparam int unsigned INSTR_TYPE_LSB      = 8;
   localparam int unsigned INSTR_MOTOR_LSB     = 16;

   // ------------------------------------------------------------
   // Return stack
   // ------------------------------------------------------------
   localparam int unsigned STACK_DEPTH = 8;
   localparam logic [3:0]  STACK_FULL  = 4'h8;

   // ------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_INSTR  = 8'h04;
   localparam logic [7:0]  ADDR_VALUE  = 8'h08;
   localparam logic [7:0]  ADDR_EXEC   = 8'h0c;
   localparam logic [7:0]  ADDR_ACCU   = 8'h10;
   localparam logic [7:0]  ADDR_PC     = 8'h14;
   localparam logic [7:0]  ADDR_STATUS = 8'h18;
   localparam int unsigned CTRL_START_BIT   = 0;
   localparam int unsigned CTRL_CLEAR_BIT   = 1;
   localparam int unsigned EXEC_GO_BIT      = 0;
   localparam int unsigned STAT_WAIT_BIT    = 0;
   localparam int unsigned STAT_TIMEOUT_BIT = 1;
   localparam int unsigned STAT_DEPTH_LSB   = 4;
   localparam int unsigned STAT_INPUTS_LSB  = 8;
   localparam logic [31:0] RST_WORD = 32'h00000000;

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } pfs_state_e;

endpackage

// ### verilog/pfs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_sequencer
   import pfs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic        pos_reached_i,
   input  wire logic        home_switch_i,
   input  wire logic        end_switch_left_i,
   input  wire logic        end_switch_right_i,
   input  wire logic        homing_done_i,
   output var  logic [31:0] program_counter_o,
   output var  logic        waiting_o,
   output var  logic        timeout_error_flag_o
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [4:0]  sync1_q;
   logic [4:0]  sync2_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic [31:0] instr_q;
   logic [31:0] value_q;
   logic [31:0] accu_q;
   logic [31:0] pc_q;
   logic [31:0] pc_d;
   logic [31:0] stack_q [STACK_DEPTH];
   logic [3:0]  depth_q;
   logic [3:0]  depth_d;
   logic        push;
   logic        flag_q;
   logic        flag_set;
   logic        flag_clr;
   pfs_state_e  state_q;
   pfs_state_e  state_d;
   logic [7:0]  wtype_q;
   logic        wmotor_ok_q;
   logic        timed_q;
   logic [31:0] remain_q;
   logic [31:0] remain_d;
   logic [31:0] pre_q;
   logic        tick;
   logic        wb_req;
   logic        wr;
   logic        start;
   logic        clear;
   logic        exec;
   logic [7:0]  op;
   logic [7:0]  typ;
   logic [7:0]  motor;
   logic [31:0] count;
   logic        cond;

   assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr     = wb_req & wb_we_i;
   assign start  = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_START_BIT];
   assign clear  = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_CLEAR_BIT];
   // A new instruction is refused while a wait is still running.
   assign exec   = wr & (wb_adr_i == ADDR_EXEC) & wb_sel_i[0] & wb_dat_i[EXEC_GO_BIT]
                   & (state_q == ST_IDLE) & ~start;
   assign op     = instr_q[INSTR_OP_LSB +: 8];
   assign typ    = instr_q[INSTR_TYPE_LSB +: 8];
   assign motor  = instr_q[INSTR_MOTOR_LSB +: 8];
   assign count  = (value_q == VALUE_FROM_ACC) ? accu_q : value_q;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // Motion core inputs pass two flip-flops first
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {homing_done_i, end_switch_right_i, end_switch_left_i,
                     home_switch_i, pos_reached_i};
         sync2_q <= sync1_q;
      end
   end

   // Only one motor exists; another motor number never meets its condition.
   always_comb begin
      cond = 1'b0;
      if (wmotor_ok_q) begin
         unique case (wtype_q)
            WT_POSITION:    cond = sync2_q[0];
            WT_HOME_SWITCH: cond = sync2_q[1];
            WT_END_SWITCH:  cond = sync2_q[2] | sync2_q[3];
            WT_HOMING_DONE: cond = sync2_q[4];
            default:        cond = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Tick prescaler, restarted when a wait begins
   // ------------------------------------------------------------
   // ten millisecond tick
   always_ff @(posedge clk_i) begin
      if (rst_i || exec || pre_q == TICK_CYC - 1) begin
         pre_q <= RST_WORD;
      end else begin
         pre_q <= pre_q + 32'h1;
      end
   end
   assign tick = (pre_q == TICK_CYC - 1) & (state_q == ST_WAIT);

   // ------------------------------------------------------------
   // Instruction execution
   // ------------------------------------------------------------
   always_comb begin
      pc_d     = pc_q;
      depth_d  = depth_q;
      push     = 1'b0;
      state_d  = state_q;
      remain_d = remain_q;
      flag_set = 1'b0;
      flag_clr = 1'b0;
      if (exec) begin
         pc_d = pc_q + 32'h1;
         unique case (op)
            OP_JUMP_ALWAYS: pc_d = value_q;
            OP_JUMP_CONDITIONAL: begin
               if (typ == JC_COND_TIMEOUT && flag_q) begin
                  pc_d     = value_q;
                  flag_clr = 1'b1;
               end
            end
            OP_CALL_SUBROUTINE: begin
               if (depth_q != STACK_FULL) begin
                  push    = 1'b1;
                  depth_d = depth_q + 4'h1;
                  pc_d    = value_q;
               end
            end
            OP_RETURN_SUBROUTINE: begin
               if (depth_q != 4'h0) begin
                  depth_d = depth_q - 4'h1;
                  pc_d    = stack_q[3'(depth_q - 4'h1)] + 32'h1;
               end
            end
            OP_WAIT: begin
               if (typ <= WT_HOMING_DONE) begin
                  pc_d     = pc_q;
                  state_d  = ST_WAIT;
                  remain_d = count;
               end
            end
            default: ;
         endcase
      end else if (state_q == ST_WAIT) begin
         if (wtype_q == WT_TICKS) begin
            if (remain_q == RST_WORD) begin
               state_d = ST_IDLE;
               pc_d    = pc_q + 32'h1;
            end else if (tick) begin
               remain_d = remain_q - 32'h1;
            end
         end else if (cond) begin
            state_d = ST_IDLE;
            pc_d    = pc_q + 32'h1;
         end else if (tick && timed_q) begin
            if (remain_q == 32'h1) begin
               state_d  = ST_IDLE;
               pc_d     = pc_q + 32'h1;
               flag_set = 1'b1;
            end else begin
               remain_d = remain_q - 32'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || start) begin
         pc_q    <= RST_WORD;
         depth_q <= 4'h0;
         state_q <= ST_IDLE;
      end else begin
         pc_q    <= pc_d;
         depth_q <= depth_d;
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         stack_q[3'(depth_q)] <= pc_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         remain_q    <= RST_WORD;
         wtype_q     <= WT_TICKS;
         timed_q     <= 1'b0;
         wmotor_ok_q <= 1'b0;
      end else begin
         remain_q <= remain_d;
         if (exec) begin
            wtype_q     <= typ;
            timed_q     <= (count != RST_WORD);
            wmotor_ok_q <= (motor == MOTOR_ONLY);
         end
      end
   end

   // Set wins over any clear arriving in the same cycle.
   // sticky timeout flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else if (flag_set) begin
         flag_q <= 1'b1;
      end else if (start || clear || flag_clr) begin
         flag_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr_q <= RST_WORD;
         value_q <= RST_WORD;
         accu_q  <= RST_WORD;
      end else if (wr) begin
         if (wb_adr_i == ADDR_INSTR) begin
            instr_q <= merge(instr_q, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADDR_VALUE) begin
            value_q <= merge(value_q, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADDR_ACCU) begin
            accu_q <= merge(accu_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   // Every access is acknowledged once; unmapped reads return zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= RST_WORD;
      end else begin
         ack_q <= wb_req;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               ADDR_INSTR:  rdat_q <= instr_q;
               ADDR_VALUE:  rdat_q <= value_q;
               ADDR_ACCU:   rdat_q <= accu_q;
               ADDR_PC:     rdat_q <= pc_q;
               ADDR_STATUS: begin
                  rdat_q                       <= RST_WORD;
                  rdat_q[STAT_WAIT_BIT]        <= (state_q == ST_WAIT);
                  rdat_q[STAT_TIMEOUT_BIT]     <= flag_q;
                  rdat_q[STAT_DEPTH_LSB +: 4]  <= depth_q;
                  rdat_q[STAT_INPUTS_LSB +: 5] <= sync2_q;
               end
               default:     rdat_q <= RST_WORD;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs straight from flip-flops
   // ------------------------------------------------------------
   assign wb_ack_o             = ack_q;
   assign wb_dat_o             = rdat_q;
   assign program_counter_o    = pc_q;
   assign waiting_o            = (state_q == ST_WAIT);
   assign timeout_error_flag_o = flag_q;

endmodule // pfs_sequencer
`default_nettype wire

// ### verification/pfs_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_sequencer_asserts
   import pfs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        pos_reached_i,
   input wire logic        home_switch_i,
   input wire logic        end_switch_left_i,
   input wire logic        end_switch_right_i,
   input wire logic        homing_done_i,
   input wire logic [31:0] program_counter_o,
   input wire logic        waiting_o,
   input wire logic        timeout_error_flag_o
);
   logic        req;
   logic        start_w;
   logic [31:0] wcnt_q;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign start_w = req && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[0];
   // Counts how long the current wait has lasted, so a timeout can be tied to its length.
   always_ff @(posedge clk_i) begin
      if (rst_i || !waiting_o) begin
         wcnt_q <= 32'h0;
      end else begin
         wcnt_q <= wcnt_q + 32'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_next: assert property (req |=> wb_ack_o) else $error("no ack after request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_pc_held:
      assert property (waiting_o ##1 waiting_o |-> $stable(program_counter_o))
      else $error("pc moved while waiting");
   chk_wait_exit:
      assert property ($fell(waiting_o) && !$past(start_w)
         |-> program_counter_o == $past(program_counter_o) + 32'h1) else $error("bad exit pc");
   chk_wait_cause:
      assert property ($rose(waiting_o) |-> $past(req && wb_we_i && wb_adr_i == ADDR_EXEC))
      else $error("wait without exec");
   chk_flag_timeout:
      assert property ($rose(timeout_error_flag_o) |-> $fell(waiting_o) && wcnt_q >= TICK_CYC - 1)
      else $error("flag without timeout");
   chk_flag_clear:
      assert property ($fell(timeout_error_flag_o) |-> $past(req && wb_we_i
         && (wb_adr_i == ADDR_CTRL || wb_adr_i == ADDR_EXEC))) else $error("flag lost");
   chk_start_clear:
      assert property (start_w |=> program_counter_o == 32'h0 && !timeout_error_flag_o
         && !waiting_o) else $error("start did not clear");
   cover property ($rose(timeout_error_flag_o));
   cover property ($fell(waiting_o));
   cover property (start_w);
endmodule // pfs_sequencer_asserts
bind pfs_sequencer pfs_sequencer_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .pos_reached_i(pos_reached_i), .home_switch_i(home_switch_i),
   .end_switch_left_i(end_switch_left_i), .end_switch_right_i(end_switch_right_i),
   .homing_done_i(homing_done_i), .program_counter_o(program_counter_o),
   .waiting_o(waiting_o), .timeout_error_flag_o(timeout_error_flag_o));
`default_nettype wire

// ### verification/pfs_motion_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_motion_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [4:0] raise_i,
   input  wire logic [3:0] lag_i,
   output var  logic [4:0] stat_o
);
   logic [3:0] cnt_q;
   // status follows the request after a chosen lag.
   always_ff @(posedge clk_i) begin
      if (rst_i || stat_o == raise_i) begin
         cnt_q <= 4'h0;
         if (rst_i) begin
            stat_o <= 5'h00;
         end
      end else if (cnt_q >= lag_i) begin
         stat_o <= raise_i;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule // pfs_motion_model
`default_nettype wire

// ### verification/pfs_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module pfs_sequencer_test;
   import pfs_pkg::*;
   localparam int unsigned T = 5;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, wt, flg;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0, lag = 4'h0;
   logic [31:0] dat = 32'h0, rdat, rd, pc_o, mpc;
   logic [4:0]  raise = 5'h00, st;
   logic [15:0] rnd = 16'h0013;
   logic [31:0] stk[$];
   int          num_errors = 0, cmp_count = 0, tmo = 0;
   pfs_sequencer #(.TICK_CYC(T)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .pos_reached_i(st[0]), .home_switch_i(st[1]),
      .end_switch_left_i(st[2]), .end_switch_right_i(st[3]), .homing_done_i(st[4]),
      .program_counter_o(pc_o), .waiting_o(wt), .timeout_error_flag_o(flg));
   pfs_motion_model u_motion (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise), .lag_i(lag),
      .stat_o(st));
   initial forever #50 clk_i = ~clk_i;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic test_done;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      tmo <= tmo + 1;
      if (tmo == 20000) begin
         num_errors++;
         test_done;
      end
   end
   // The master waits for ack however long it takes; only the bench timeout ends a wait.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
      do begin @(posedge clk_i); end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic exec(input logic [7:0] op, ty, input logic [31:0] v);
      bus(1'b1, ADDR_INSTR, {8'h00, MOTOR_ONLY, ty, op});
      bus(1'b1, ADDR_VALUE, v);
      bus(1'b1, ADDR_EXEC, 32'h1);
   endtask
   task automatic step(input logic [7:0] op, input logic [31:0] v);
      exec(op, 8'h00, v);
      if (op == OP_JUMP_ALWAYS) mpc = v;
      else if (op == OP_CALL_SUBROUTINE && stk.size() < 8) begin stk.push_back(mpc); mpc = v; end
      else if (op == OP_RETURN_SUBROUTINE && stk.size() > 0) mpc = stk.pop_back() + 32'h1;
      else mpc++;
      `CHK(pc_o, mpc)
      bus(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rd[7:4], 4'(stk.size()))
   endtask
   task automatic wait_end(output int n);
      n = 0;
      while (wt !== 1'b0 && n < 2000) begin @(posedge clk_i); n++; end
   endtask
   task automatic timed(input logic [7:0] ty, input logic [31:0] v, input int k, input logic ef);
      int n;
      exec(OP_WAIT, ty, v);
      wait_end(n);
      mpc++;
      `CHK(n >= k * T - 1 && n <= k * T + 2, 1'b1)
      `CHK(pc_o, mpc)
      `CHK(flg, ef)
   endtask
   initial begin
      int n;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK(pc_o, 32'h0)
      mpc = 32'h0;
      rnd = lfsr(rnd);
      step(OP_JUMP_ALWAYS, {16'h0, rnd});
      for (int i = 0; i < 9; i++) begin
         rnd = lfsr(rnd);
         step(OP_CALL_SUBROUTINE, {16'h0, rnd});
      end
      for (int i = 0; i < 9; i++) step(OP_RETURN_SUBROUTINE, 32'h0);
      // The accumulator is kept non-negative before the accumulator-sourced wait.
      // non-negative accumulator
      bus(1'b1, ADDR_ACCU, 32'h3);
      timed(WT_TICKS, 32'h2, 2, 1'b0);
      timed(WT_TICKS, VALUE_FROM_ACC, 3, 1'b0);
      for (int t = 1; t <= 4; t++) begin
         lag <= 4'(t * 3);
         exec(OP_WAIT, 8'(t), 32'h0);
         repeat (3 * T) @(posedge clk_i);
         `CHK(wt, 1'b1)
         `CHK(pc_o, mpc)
         raise <= (t == 3) ? (rnd[0] ? 5'h04 : 5'h08) : ((t == 4) ? 5'h10 : 5'(t));
         wait_end(n);
         mpc++;
         `CHK(pc_o, mpc)
         `CHK(flg, 1'b0)
         raise <= 5'h00;
         rnd = lfsr(rnd);
         repeat (20) @(posedge clk_i);
      end
      timed(WT_POSITION, 32'h3, 3, 1'b1);
      repeat (10) @(posedge clk_i);
      `CHK(flg, 1'b1)
      exec(OP_JUMP_CONDITIONAL, JC_COND_TIMEOUT, 32'h40);
      mpc = 32'h40;
      `CHK(pc_o, mpc)
      exec(OP_JUMP_CONDITIONAL, JC_COND_TIMEOUT, 32'h80);
      mpc++;
      `CHK(pc_o, mpc)
      exec(OP_WAIT, 8'h05, 32'h0);
      mpc++;
      `CHK(pc_o, mpc)
      `CHK(wt, 1'b0)
      // Another motor number must ignore this motor's status and time out instead.
      raise <= 5'h01;
      bus(1'b1, ADDR_INSTR, {8'h00, 8'h01, WT_POSITION, OP_WAIT});
      bus(1'b1, ADDR_VALUE, VALUE_FROM_ACC);
      bus(1'b1, ADDR_EXEC, 32'h1);
      wait_end(n);
      mpc++;
      `CHK(n >= 3 * T - 1 && n <= 3 * T + 2, 1'b1)
      `CHK(pc_o, mpc)
      `CHK(flg, 1'b1)
      raise <= 5'h00;
      bus(1'b1, ADDR_CTRL, 32'h2);
      `CHK(flg, 1'b0)
      timed(WT_HOME_SWITCH, 32'h1, 1, 1'b1);
      bus(1'b1, ADDR_CTRL, 32'h2);
      `CHK(flg, 1'b0)
      step(OP_CALL_SUBROUTINE, 32'h10);
      bus(1'b1, ADDR_CTRL, 32'h1);
      mpc = 32'h0;
      stk.delete();
      step(OP_RETURN_SUBROUTINE, 32'h0);
      bus(1'b0, ADDR_PC, 32'h0);
      `CHK(rd, mpc)
      bus(1'b0, 8'h1c, 32'h0);
      `CHK(rd, 32'h0)
      test_done;
   end
endmodule // pfs_sequencer_test
`default_nettype wire
